/* File: hw/process_image_regs.vh */
// register offsets, field layouts and constants of the process image input block
`ifndef PROCESS_IMAGE_REGS_VH
`define PROCESS_IMAGE_REGS_VH
`define OFS_DIGITAL_INPUT 8'h00
`define OFS_ANALOG_LOW0 8'h04
`define OFS_ANALOG_HIGH0 8'h08
`define OFS_ANALOG_LOW1 8'h0C
`define OFS_ANALOG_HIGH1 8'h10
`define OFS_PIN_INPUT 8'h14
`define OFS_PIN_CONFIG 8'h18
`define OFS_PIN_OUTPUT 8'h1C
`define OFS_PWM_CTRL 8'h20
`define OFS_CTRL 8'h24
`define OFS_STATUS 8'h28
`define OFS_TEMP_BASE 8'h40
`define OFS_PERSIST_OUT_BASE 8'h80
`define OFS_PERSIST_IN_BASE 8'h00
`define PERSIST_WINDOW_BIT 7
`define ADDR_WIDTH 8
`define PERSIST_BYTES 32
`define AVG_COUNT 4'hA
`define TEMP_SPAN 8'h20
`define ADC_MAX 10'h3FF
`define PIN_MODE_INPUT 2'h0
`define PIN_MODE_OUTPUT 2'h1
`define PIN_MODE_SENSOR 2'h2
`define PWM_MODE_FREQ 2'h3
`define SENSOR_NEG_BIT 15
`define UNMAPPED_READ 32'h0000_0000
`endif

/* File: hw/process_image_input_bytes.v */
// controller-side process image: input bytes, sensor words and persistent block
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "process_image_regs.vh"
module process_image_input_bytes #(
   parameter PINS = 4,
   parameter ANALOG_CHANNELS = 2
) (
   input wire sys_clk, // 10 MHz system clock
   input wire rst, // synchronous reset, active high
   input wire [`ADDR_WIDTH-1:0] avs_address, // byte address
   input wire avs_read, // read strobe
   input wire avs_write, // write strobe
   input wire [31:0] avs_writedata, // write data
   input wire [3:0] avs_byteenable, // byte lanes
   output reg [31:0] avs_readdata, // read data
   output wire avs_waitrequest, // stall
   input wire [7:0] digital_in_pins, // debounced digital input pins
   input wire [ANALOG_CHANNELS*10-1:0] adc_sample, // raw conversion per channel
   input wire adc_sample_valid, // one-cycle pulse, new conversions
   input wire [PINS-1:0] pin_in, // pin levels from pads
   output wire [PINS-1:0] pin_out, // pin drive value
   output wire [PINS-1:0] pin_oe, // pin output enable
   output wire [PINS-1:0] pin_pullup_en, // pull-up per pin
   input wire [PINS*16-1:0] sensor_raw, // sensor temperature magnitude per pin
   input wire [PINS-1:0] sensor_negative, // sensor reports below zero
   input wire exchange_strobe, // one-cycle pulse, exchange cycle boundary
   input wire power_fail, // supply failing, level from pin
   input wire power_up_restore, // one-cycle pulse after start: present saved block
   output wire pwm_enable, // pwm outputs allowed
   output wire [1:0] pwm_mode // requested pwm mode, passed through ungated
);
   reg [1:0] req_wait;
   reg pf_d;
   reg [7:0] digital_input_byte;
   reg [7:0] pin_input_byte;
   reg [7:0] pin_config_byte;
   reg [7:0] pin_output_byte;
   reg [7:0] pwm_ctrl;
   reg [7:0] ctrl;
   reg [3:0] avg_cnt;
   reg [31:0] next_readdata;

   reg [7:0] persist_out_block [0:`PERSIST_BYTES-1];
   reg [7:0] persist_store [0:`PERSIST_BYTES-1];
   reg [7:0] persist_in_block [0:`PERSIST_BYTES-1];

   wire [7:0] di_s2;
   wire [PINS-1:0] pin_s2;
   wire pf_s2;
   wire [ANALOG_CHANNELS*16-1:0] analog_reading_word;
   wire [PINS*16-1:0] sensor_temperature_word;
   wire [PINS-1:0] pin_is_sensor;
   wire any_sensor;
   wire pwm_req_enable;
   wire [1:0] pwm_req_mode;
   wire freq_blocked;
   wire persist_enable;
   wire precision_type;
   wire avg_last;
   wire save_edge;
   wire [4:0] persist_idx;
   wire persist_hit;
   wire temp_hit;
   wire [1:0] temp_pin;
   wire [7:0] temp_low;
   wire [7:0] temp_high;
   wire wr_go;
   wire rd_take;
   wire wr_reg;
   wire wr_pin_config;
   wire wr_pin_output;
   wire wr_pwm_ctrl;
   wire wr_ctrl;
   integer i;
   integer j;

   // every access takes two cycles; the bus sees waitrequest low on the second
   // read data is loaded on the first, so it already stands when waitrequest drops
   assign wr_go = avs_write && req_wait == 2'h1;
   assign rd_take = avs_read && req_wait == 2'h0;
   assign avs_waitrequest = (avs_read || avs_write) && req_wait != 2'h1;

   always @(posedge sys_clk) begin
      if (rst)
         req_wait <= 2'h0;
      else if ((avs_read || avs_write) && req_wait == 2'h0)
         req_wait <= 2'h1;
      else
         req_wait <= 2'h0;
   end

   // pad inputs and power-fail line are asynchronous to sys_clk
   pad_sync #(
      .WIDTH(8)
   ) digital_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(digital_in_pins),
      .sync_out(di_s2)
   );

   pad_sync #(
      .WIDTH(PINS)
   ) pin_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(pin_in),
      .sync_out(pin_s2)
   );

   pad_sync #(
      .WIDTH(1)
   ) power_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(power_fail),
      .sync_out(pf_s2)
   );

   // delayed copy gives the rising edge of power fail
   always @(posedge sys_clk) begin
      if (rst)
         pf_d <= 1'b0;
      else
         pf_d <= pf_s2;
   end

   // pin configuration: two bits per pin
   genvar g;
   generate
      for (g = 0; g < PINS; g = g + 1) begin : pin_mode
         wire [1:0] mode = pin_config_byte[2*g+1:2*g];
         assign pin_oe[g] = mode == `PIN_MODE_OUTPUT;
         assign pin_is_sensor[g] = mode == `PIN_MODE_SENSOR;
         assign pin_out[g] = pin_output_byte[g];
         // pull-up only meaningful while the pin is an input
         assign pin_pullup_en[g] = mode == `PIN_MODE_INPUT && pin_output_byte[g];
      end
   endgenerate

   assign any_sensor = |pin_is_sensor;
   assign pwm_req_enable = pwm_ctrl[0];
   assign pwm_req_mode = pwm_ctrl[2:1];
   // frequency mode cannot coexist with sensor timing, so pwm is shut off
   assign freq_blocked = any_sensor && pwm_req_mode == `PWM_MODE_FREQ;
   assign pwm_enable = pwm_req_enable && !freq_blocked;
   assign pwm_mode = pwm_req_mode;
   assign persist_enable = ctrl[0];
   assign precision_type = ctrl[1];

   // ten-sample averaging per channel
   assign avg_last = avg_cnt == `AVG_COUNT - 4'h1;
   always @(posedge sys_clk) begin
      if (rst)
         avg_cnt <= 4'h0;
      else if (adc_sample_valid)
         avg_cnt <= avg_last ? 4'h0 : avg_cnt + 4'h1;
   end

   genvar c;
   generate
      for (c = 0; c < ANALOG_CHANNELS; c = c + 1) begin : analog_chan
         reg [13:0] acc;
         reg [9:0] mean;
         reg [15:0] word;
         wire [13:0] acc_next = acc + {4'h0, adc_sample[c*10 +: 10]};
         wire [13:0] quotient = acc_next / {10'h0, `AVG_COUNT};
         // a mean of ten samples cannot pass the maximum; the clamp only pins the bound down
         wire [9:0] clamped = (quotient > {4'h0, `ADC_MAX}) ? `ADC_MAX : quotient[9:0];
         always @(posedge sys_clk) begin
            if (rst) begin
               acc <= 14'h0;
               mean <= 10'h0;
            end else if (adc_sample_valid) begin
               if (avg_last) begin
                  mean <= clamped;
                  acc <= 14'h0;
               end else
                  acc <= acc_next;
            end
         end
         // published value moves only at the exchange boundary
         always @(posedge sys_clk) begin
            if (rst)
               word <= 16'h0000;
            else if (exchange_strobe)
               word <= {6'h00, mean};
         end
         assign analog_reading_word[c*16 +: 16] = word;
      end
   endgenerate

   // snapshot at exchange boundary keeps the image coherent
   always @(posedge sys_clk) begin
      if (rst) begin
         digital_input_byte <= 8'h00;
         pin_input_byte <= 8'h00;
      end else if (exchange_strobe) begin
         digital_input_byte <= di_s2;
         pin_input_byte <= {{(8-PINS){1'b0}}, pin_s2};
      end
   end

   // only sensor pins publish a temperature; other pins read zero
   generate
      for (g = 0; g < PINS; g = g + 1) begin : sensor_pin
         reg [15:0] word;
         always @(posedge sys_clk) begin
            if (rst)
               word <= 16'h0000;
            else if (exchange_strobe) begin
               if (!pin_is_sensor[g])
                  word <= 16'h0000;
               else if (precision_type)
                  // precision type: tenths, sign in top bit
                  word <= {sensor_negative[g], sensor_raw[g*16 +: 15]};
               else
                  // basic type: whole degrees in high byte
                  word <= {sensor_raw[g*16 +: 8], 8'h00};
            end
         end
         assign sensor_temperature_word[g*16 +: 16] = word;
      end
   endgenerate

   // persistent area: out-block written by host, in-block shows saved copy
   assign persist_idx = avs_address[6:2];
   assign persist_hit = avs_address[`PERSIST_WINDOW_BIT];
   assign save_edge = pf_s2 && !pf_d && persist_enable;
   assign wr_reg = wr_go && !persist_hit && avs_byteenable[0];
   assign wr_pin_config = wr_reg && avs_address == `OFS_PIN_CONFIG;
   assign wr_pin_output = wr_reg && avs_address == `OFS_PIN_OUTPUT;
   assign wr_pwm_ctrl = wr_reg && avs_address == `OFS_PWM_CTRL;
   assign wr_ctrl = wr_reg && avs_address == `OFS_CTRL;

   always @(posedge sys_clk) begin
      if (rst)
         pin_config_byte <= 8'h00;
      else if (wr_pin_config)
         pin_config_byte <= avs_writedata[7:0];
   end

   always @(posedge sys_clk) begin
      if (rst)
         pin_output_byte <= 8'h00;
      else if (wr_pin_output)
         pin_output_byte <= avs_writedata[7:0];
   end

   always @(posedge sys_clk) begin
      if (rst)
         pwm_ctrl <= 8'h00;
      else if (wr_pwm_ctrl)
         pwm_ctrl <= avs_writedata[7:0];
   end

   always @(posedge sys_clk) begin
      if (rst)
         ctrl <= 8'h00;
      else if (wr_ctrl)
         ctrl <= avs_writedata[7:0];
   end

   // saved store survives rst: it models non-volatile memory
   always @(posedge sys_clk) begin
      if (wr_go && persist_hit && avs_byteenable[0])
         persist_out_block[persist_idx] <= avs_writedata[7:0];
   end

   // a new save replaces the old copy only on a fresh power-fail edge
   always @(posedge sys_clk) begin
      for (i = 0; i < `PERSIST_BYTES; i = i + 1) begin
         if (save_edge)
            persist_store[i] <= persist_out_block[i];
      end
   end

   // restored block reaches the host unchanged
   always @(posedge sys_clk) begin
      for (j = 0; j < `PERSIST_BYTES; j = j + 1) begin
         if (power_up_restore)
            persist_in_block[j] <= persist_store[j];
      end
   end

   // read decode is combinational; the answer is registered in the first request cycle
   assign temp_hit = avs_address >= `OFS_TEMP_BASE && avs_address < `OFS_TEMP_BASE + `TEMP_SPAN;
   assign temp_pin = avs_address[4:3];
   assign temp_low = sensor_temperature_word[temp_pin*16 +: 8];
   assign temp_high = sensor_temperature_word[temp_pin*16+8 +: 8];
   always @* begin
      next_readdata = `UNMAPPED_READ;
      if (persist_hit)
         next_readdata = {24'h0, persist_in_block[persist_idx]};
      else if (temp_hit) begin
         if (avs_address[2])
            next_readdata = {24'h0, temp_high};
         else
            next_readdata = {24'h0, temp_low};
      end else if (avs_address == `OFS_DIGITAL_INPUT)
         next_readdata = {24'h0, digital_input_byte};
      else if (avs_address == `OFS_ANALOG_LOW0)
         next_readdata = {24'h0, analog_reading_word[7:0]};
      else if (avs_address == `OFS_ANALOG_HIGH0)
         next_readdata = {24'h0, analog_reading_word[15:8]};
      else if (avs_address == `OFS_ANALOG_LOW1)
         next_readdata = {24'h0, analog_reading_word[23:16]};
      else if (avs_address == `OFS_ANALOG_HIGH1)
         next_readdata = {24'h0, analog_reading_word[31:24]};
      else if (avs_address == `OFS_PIN_INPUT)
         next_readdata = {24'h0, pin_input_byte};
      else if (avs_address == `OFS_PIN_CONFIG)
         next_readdata = {24'h0, pin_config_byte};
      else if (avs_address == `OFS_PIN_OUTPUT)
         next_readdata = {24'h0, pin_output_byte};
      else if (avs_address == `OFS_PWM_CTRL)
         next_readdata = {24'h0, pwm_ctrl};
      else if (avs_address == `OFS_CTRL)
         next_readdata = {24'h0, ctrl};
      else if (avs_address == `OFS_STATUS)
         next_readdata = {29'h0, any_sensor, pwm_enable, pf_s2};
   end

   always @(posedge sys_clk) begin
      if (rst)
         avs_readdata <= `UNMAPPED_READ;
      else if (rd_take)
         avs_readdata <= next_readdata;
   end
endmodule // process_image_input_bytes

// two-flop synchroniser for lines from outside the clock domain
module pad_sync #(
   parameter WIDTH = 1
) (
   input wire sys_clk, // system clock
   input wire rst, // synchronous reset, active high
   input wire [WIDTH-1:0] async_in, // line from a pad
   output reg [WIDTH-1:0] sync_out // safe to read in the sys_clk domain
);
   reg [WIDTH-1:0] first_stage;
   // only the second stage is read; the first may be metastable
   always @(posedge sys_clk) begin
      if (rst) begin
         first_stage <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         first_stage <= async_in;
         sync_out <= first_stage;
      end
   end
endmodule // pad_sync

/* File: test/exchange_host.sv */
// host side model: marks each exchange cycle of the process image
`timescale 1ns/1ps
module exchange_host #(parameter PERIOD = 16) (
   input wire sys_clk, // system clock
   input wire rst, // synchronous reset
   output logic exchange_strobe = 1'b0 // one pulse per exchange cycle
);
   int cnt = 0;
   // free running: the host never waits on the device between cycles
   always @(posedge sys_clk) begin
      cnt <= (rst || cnt == PERIOD - 1) ? 0 : cnt + 1;
      exchange_strobe <= !rst && cnt == PERIOD - 1;
   end
endmodule // exchange_host

/* File: test/process_image_props.sv */
// port assertions of the process image input block
`timescale 1ns/1ps
`include "process_image_regs.vh"
module process_image_props #(parameter PINS = 4) (
   input wire sys_clk, rst, avs_read, avs_write, avs_waitrequest, pwm_enable,
   input wire [`ADDR_WIDTH-1:0] avs_address,
   input wire [31:0] avs_readdata,
   input wire [PINS-1:0] pin_oe, pin_pullup_en
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire ans = avs_read && !avs_waitrequest;
   chk_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read not answered after one wait cycle");
   chk_write_wait: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("write not answered after one wait cycle");
   chk_reset_inputs: assert property ($fell(rst) |-> pin_oe == 0 && pin_pullup_en == 0 && !pwm_enable)
      else $error("pins not inputs after reset");
   chk_pullup_input: assert property ((pin_oe & pin_pullup_en) == 0)
      else $error("pull-up on a driven pin");
   chk_byte_wide: assert property (ans |-> avs_readdata[31:8] == 0)
      else $error("read data wider than a byte");
   chk_analog_top: assert property (ans && avs_address inside {`OFS_ANALOG_HIGH0, `OFS_ANALOG_HIGH1} |-> avs_readdata[7:2] == 0)
      else $error("analog high byte above two bits");
   chk_pin_unused: assert property (ans && avs_address == `OFS_PIN_INPUT |-> avs_readdata[7:4] == 0)
      else $error("unused pin bits set");
   chk_data_stands: assert property (!$past(avs_read) && !$past(rst) |-> $stable(avs_readdata))
      else $error("read data moved without a read");
   cov_read: cover property (ans);
   cov_write: cover property (avs_write && !avs_waitrequest);
   cov_pullup: cover property (pin_pullup_en != 0);
endmodule // process_image_props
bind process_image_input_bytes process_image_props #(.PINS(PINS)) process_image_props_inst (.sys_clk(sys_clk),
   .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .pwm_enable(pwm_enable),
   .avs_address(avs_address), .avs_readdata(avs_readdata), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en));

/* File: test/test_process_image_input_bytes.sv */
// self-checking bench of the process image input block
`timescale 1ns/1ps
`include "process_image_regs.vh"
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_process_image_input_bytes;
   logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, adc_sample_valid = 0, power_fail = 0, power_up_restore = 0;
   logic [7:0] avs_address = 0, digital_in_pins = 0;
   logic [7:0] pb [32];
   logic [31:0] avs_writedata = 0, avs_readdata, q;
   logic [19:0] adc_sample = 0;
   logic [3:0] pin_float = 0, sensor_negative = 0, pin_out, pin_oe, pin_pullup_en;
   logic [63:0] sensor_raw = 0;
   logic [15:0] raw, w;
   logic [1:0] pwm_mode;
   logic avs_waitrequest, pwm_enable, exchange_strobe;
   int mismatches = 0, checks_done = 0, sum;
   // open pins float; the bench drives a random value there and holds it over each check
   wire [3:0] pin_wire = (pin_oe & pin_out) | (~pin_oe & (pin_pullup_en | pin_float));
   always #50 sys_clk = ~sys_clk;
   process_image_input_bytes process_image_input_bytes_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .digital_in_pins(digital_in_pins),
      .adc_sample(adc_sample), .adc_sample_valid(adc_sample_valid), .pin_in(pin_wire), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .sensor_raw(sensor_raw), .sensor_negative(sensor_negative),
      .exchange_strobe(exchange_strobe), .power_fail(power_fail), .power_up_restore(power_up_restore),
      .pwm_enable(pwm_enable), .pwm_mode(pwm_mode));
   exchange_host #(.PERIOD(16)) exchange_host_inst (.sys_clk(sys_clk), .rst(rst), .exchange_strobe(exchange_strobe));
   function automatic [15:0] temp_word(input [15:0] r, input neg, input prec);
      temp_word = prec ? {neg, r[14:0]} : {r[7:0], 8'h00};
   endfunction
   task automatic bus(input [7:0] a, input rw, input [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      if (rw) avs_write <= 1;
      else avs_read <= 1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 0;
      avs_read <= 0;
   endtask
   task automatic rd(input [7:0] a, input [31:0] e);
      bus(a, 0, 0);
      `CHECK(q, e)
   endtask
   task settle;
      repeat (40) @(posedge sys_clk);
   endtask
   task stop_test;
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      stop_test();
   end
   initial begin
      void'($urandom(33131));
      repeat (4) @(posedge sys_clk);
      rst <= 0;
      for (int i = 0; i < 5; i++) rd(8'(4 * i), 0);
      rd(`OFS_TEMP_BASE, 0);
      rd(8'h2C, `UNMAPPED_READ);
      for (int i = 0; i < 3; i++) begin
         digital_in_pins <= (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($urandom);
         pin_float <= 4'($urandom);
         settle;
         rd(`OFS_DIGITAL_INPUT, {24'h0, digital_in_pins});
         rd(`OFS_PIN_INPUT, {28'h0, pin_float});
      end
      bus(`OFS_PIN_CONFIG, 1, 32'h0000_0055);
      bus(`OFS_PIN_OUTPUT, 1, 32'h0000_0005);
      settle;
      `CHECK({pin_oe, pin_out}, 8'hF5)
      rd(`OFS_PIN_INPUT, 32'h0000_0005);
      bus(`OFS_PIN_CONFIG, 1, 0);
      bus(`OFS_PIN_OUTPUT, 1, 32'h0000_000F);
      pin_float <= 0;
      settle;
      rd(`OFS_PIN_INPUT, 32'h0000_000F);
      bus(`OFS_PIN_OUTPUT, 1, 0);
      sum = 0;
      for (int i = 0; i < 10; i++) begin
         raw = 16'($urandom_range(1023));
         sum += raw;
         @(posedge sys_clk);
         adc_sample <= {10'h3FF, raw[9:0]};
         adc_sample_valid <= 1;
         @(posedge sys_clk);
         adc_sample_valid <= 0;
      end
      settle;
      w = 16'(sum / 10);
      rd(`OFS_ANALOG_LOW0, {24'h0, w[7:0]});
      rd(`OFS_ANALOG_HIGH0, {24'h0, w[15:8]});
      rd(`OFS_ANALOG_LOW1, 32'h0000_00FF);
      rd(`OFS_ANALOG_HIGH1, 32'h0000_0003);
      for (int m = 0; m < 2; m++) begin
         raw = 16'($urandom);
         sensor_raw <= {4{raw}};
         sensor_negative <= 4'($urandom);
         bus(`OFS_CTRL, 1, 32'(2 * m));
         bus(`OFS_PIN_CONFIG, 1, 32'h0000_00AA);
         settle;
         w = temp_word(raw, sensor_negative[3 * m], m[0]);
         rd(8'(`OFS_TEMP_BASE + 24 * m), {24'h0, w[7:0]});
         rd(8'(`OFS_TEMP_BASE + 24 * m + 4), {24'h0, w[15:8]});
      end
      bus(`OFS_PWM_CTRL, 1, 32'h0000_0007);
      settle;
      `CHECK(pwm_enable, 1'b0)
      bus(`OFS_PIN_CONFIG, 1, 0);
      bus(`OFS_PWM_CTRL, 1, 32'h0000_0007);
      settle;
      `CHECK({pwm_enable, pwm_mode}, 3'h7)
      bus(`OFS_CTRL, 1, 32'h0000_0001);
      for (int i = 0; i < 32; i++) begin
         pb[i] = 8'($urandom);
         bus(8'(8'h80 + 4 * i), 1, {24'h0, pb[i]});
      end
      power_fail <= 1;
      repeat (4) @(posedge sys_clk);
      rst <= 1;
      power_fail <= 0;
      repeat (4) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      power_up_restore <= 1;
      @(posedge sys_clk);
      power_up_restore <= 0;
      for (int i = 0; i < 32; i++) rd(8'(8'h80 + 4 * i), {24'h0, pb[i]});
      stop_test();
   end
endmodule // test_process_image_input_bytes
